// ==== src/icr_evt_if.sv ====
`timescale 1ns/1ns
interface icr_evt_if;
    logic ext_edge;
    logic port_change;
    logic reset_pin_low;

    modport src (output ext_edge, output port_change, output reset_pin_low);
    modport snk (input  ext_edge, input  port_change, input  reset_pin_low);
endinterface : icr_evt_if

// ==== src/icr_pin_sync.sv ====
`timescale 1ns/1ns
module icr_pin_sync
    import icr_pkg::*;
(
    // clock and reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // pins
    input  wire logic [icr_pkg::ICR_PORT_W-1:0] port_pins,
    input  wire logic                  ext_irq_pin,
    input  wire logic                  external_reset_pin_n,
    // events
    icr_evt_if.src                     evt
);
    logic [ICR_PIN_N-1:0] pins_in;
    logic [ICR_PIN_N-1:0] sync_vec;
    logic [ICR_PIN_N-1:0] last_vec;
    logic                 ext_rise;
    logic                 ext_fall;

    assign pins_in = {external_reset_pin_n, ext_irq_pin, port_pins};

    // two stages before any logic; the third stage is the history for edges
    for (genvar i = 0; i < ICR_PIN_N; i++) begin : g_bit
        logic meta_reg;
        logic sync_reg;
        logic last_reg;
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                meta_reg <= ICR_PIN_IDLE[i];
                sync_reg <= ICR_PIN_IDLE[i];
                last_reg <= ICR_PIN_IDLE[i];
            end else begin
                meta_reg <= pins_in[i];
                sync_reg <= meta_reg;
                last_reg <= sync_reg;
            end
        end
        assign sync_vec[i] = sync_reg;
        assign last_vec[i] = last_reg;
    end

    assign ext_rise          = sync_vec[ICR_PIN_EXT] & ~last_vec[ICR_PIN_EXT];
    assign ext_fall          = ~sync_vec[ICR_PIN_EXT] & last_vec[ICR_PIN_EXT];
    assign evt.ext_edge      = ICR_EXT_RISING ? ext_rise : ext_fall;
    // any change on any of the port pins since the previous cycle
    assign evt.port_change   = |(sync_vec[ICR_PORT_W-1:0] ^ last_vec[ICR_PORT_W-1:0]);
    assign evt.reset_pin_low = ~sync_vec[ICR_PIN_MRST];
endmodule : icr_pin_sync

// ==== src/icr_pkg.sv ====
// Operation
// [R1] The interrupt control register can be read and written and holds the enables and flags of the timer, port-change and external-pin sources.
// [R2] The interrupt control register answers at data address 0x0B and at its mirror 0x8B.
// [R3] Each flag is set when its condition occurs, whatever its own enable or the global enable says.
// [R4] Common core registers ignore the bank-select address bit, so both banks reach the same register.
// [R5] The program counter high bits are loaded from a writable holding register whenever the counter is loaded.
// [R6] A reset-pin or watchdog reset applies the other-reset values, which differ from the power-up values.
// [R7] Unimplemented locations and bits read as zero and ignore writes.
// [R8] Software keeps the indirect-bank-select and upper bank-select bits cleared.
// [R9] Interrupt service code saves and restores the program counter high holding register.
// [R10] The converter flag is set when a conversion completes.
// [R11] The register holds global enable at bit 7, converter enable at 6, timer, pin and port enables at 5 to 3, flags at 2 to 0.
// [R12] Flags stay set until software writes them to zero, and an interrupt is requested while the global enable and a flag with its enable are set.
package icr_pkg;
    localparam int ICR_DW     = 8;
    localparam int ICR_AW     = 8;
    localparam int ICR_PCH_W  = 5;
    localparam int ICR_PORT_W = 4;
    localparam int ICR_PIN_N  = ICR_PORT_W + 2;

    localparam logic [ICR_AW-1:0] ICR_ADDR_PCH    = 8'h0A;
    localparam logic [ICR_AW-1:0] ICR_ADDR_CTL    = 8'h0B;
    localparam logic [ICR_AW-1:0] ICR_ADDR_PIR    = 8'h0C;
    localparam logic [ICR_AW-1:0] ICR_BANK_MASK   = 8'h7F;
    localparam logic [ICR_AW-1:0] ICR_BANK_BIT    = 8'h80;

    localparam int ICR_B_GLB_EN   = 7;
    localparam int ICR_B_CONV_EN  = 6;
    localparam int ICR_B_T0_EN    = 5;
    localparam int ICR_B_EXT_EN   = 4;
    localparam int ICR_B_PORT_EN  = 3;
    localparam int ICR_B_T0_FLAG  = 2;
    localparam int ICR_B_EXT_FLAG = 1;
    localparam int ICR_B_PORT_FLAG = 0;
    localparam int ICR_B_CONV_FLAG = 6;

    localparam logic [ICR_DW-1:0]    ICR_ZERO        = 8'h00;
    localparam logic [ICR_DW-1:0]    ICR_CTL_POR     = 8'h00;
    localparam logic [ICR_DW-1:0]    ICR_CTL_KEEP    = 8'h01;
    localparam logic [ICR_PCH_W-1:0] ICR_PCH_RST     = 5'h00;

    localparam int                   ICR_PIN_EXT  = 4;
    localparam int                   ICR_PIN_MRST = 5;
    localparam logic [ICR_PIN_N-1:0] ICR_PIN_IDLE = 6'h20;
    localparam logic                 ICR_EXT_RISING = 1'b1;
endpackage : icr_pkg

// ==== src/icr_top.sv ====
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
module icr_top
    import icr_pkg::*;
(
    // clock and power-up reset
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    // register port
    input  wire logic [icr_pkg::ICR_AW-1:0] addr,
    input  wire logic [icr_pkg::ICR_DW-1:0] wdata,
    input  wire logic                  wr,
    input  wire logic                  rd,
    output logic      [icr_pkg::ICR_DW-1:0] rdata,
    // interrupt sources
    input  wire logic                  timer0_ovf,
    input  wire logic                  conv_done,
    input  wire logic                  ext_irq_pin,
    input  wire logic [icr_pkg::ICR_PORT_W-1:0] port_pins,
    // other reset sources
    input  wire logic                  external_reset_pin_n,
    input  wire logic                  wdt_reset,
    // program counter
    input  wire logic                  pc_load,
    output logic      [icr_pkg::ICR_PCH_W-1:0] pc_high,
    // interrupt request
    output logic                       irq_req
);
    import icr_pkg::*;

    icr_evt_if evt ();

    icr_pin_sync u_sync (
        .sys_clk              (sys_clk),
        .rst                  (rst),
        .port_pins            (port_pins),
        .ext_irq_pin          (ext_irq_pin),
        .external_reset_pin_n (external_reset_pin_n),
        .evt                  (evt.src)
    );

    logic [ICR_DW-1:0]    ctl_reg;
    logic [ICR_DW-1:0]    ctl_next;
    logic [ICR_PCH_W-1:0] pclath_reg;
    logic [ICR_PCH_W-1:0] pclath_next;
    logic [ICR_PCH_W-1:0] pc_high_reg;
    logic [ICR_PCH_W-1:0] pc_high_next;
    logic                 conv_flag_reg;
    logic                 conv_flag_next;
    logic [ICR_DW-1:0]    rdata_reg;
    logic [ICR_DW-1:0]    rdata_next;
    logic [ICR_AW-1:0]    addr_common;
    logic                 hit_ctl;
    logic                 hit_pch;
    logic                 hit_pir;
    logic                 other_rst;
    logic [3:0]           irq_src;

    // common registers drop the bank bit; the converter flag register is bank 0 only
    assign addr_common = addr & ICR_BANK_MASK;                        // [R4]
    assign hit_ctl     = (addr_common == ICR_ADDR_CTL);               // [R2]
    assign hit_pch     = (addr_common == ICR_ADDR_PCH);               // [R4]
    assign hit_pir     = (addr == ICR_ADDR_PIR);
    assign other_rst   = evt.reset_pin_low | wdt_reset;               // [R6]

    always_comb begin
        ctl_next       = ctl_reg;
        pclath_next    = pclath_reg;
        pc_high_next   = pc_high_reg;
        conv_flag_next = conv_flag_reg;
        rdata_next     = ICR_ZERO;
        // software write first, so that a same-cycle event overrides a clear
        if (wr && hit_ctl) begin
            ctl_next = wdata;                                         // [R1] [R11]
        end
        if (wr && hit_pch) begin
            pclath_next = wdata[ICR_PCH_W-1:0];                       // [R5] [R7]
        end
        if (wr && hit_pir) begin
            conv_flag_next = wdata[ICR_B_CONV_FLAG];                  // [R7] [R12]
        end
        if (timer0_ovf) begin
            ctl_next[ICR_B_T0_FLAG] = 1'b1;                           // [R3]
        end
        if (evt.ext_edge) begin
            ctl_next[ICR_B_EXT_FLAG] = 1'b1;                          // [R3]
        end
        if (evt.port_change) begin
            ctl_next[ICR_B_PORT_FLAG] = 1'b1;                         // [R3]
        end
        if (conv_done) begin
            conv_flag_next = 1'b1;                                    // [R10]
        end
        if (pc_load) begin
            pc_high_next = pclath_reg;                                // [R5]
        end
        if (rd) begin
            case (1'b1)
                hit_ctl:    rdata_next = ctl_reg;                     // [R1]
                hit_pch:    rdata_next = {{(ICR_DW-ICR_PCH_W){1'b0}}, pclath_reg}; // [R7]
                hit_pir:    rdata_next = {1'b0, conv_flag_reg, 6'h00};              // [R7]
                default:    rdata_next = ICR_ZERO;                    // [R7]
            endcase
        end
        // the port flag keeps its value over a non-power-up reset
        if (other_rst) begin
            ctl_next       = ctl_next & ICR_CTL_KEEP;                 // [R6]
            pclath_next    = ICR_PCH_RST;                             // [R6]
            pc_high_next   = ICR_PCH_RST;
            conv_flag_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctl_reg       <= ICR_CTL_POR;
            pclath_reg    <= ICR_PCH_RST;
            pc_high_reg   <= ICR_PCH_RST;
            conv_flag_reg <= 1'b0;
            rdata_reg     <= ICR_ZERO;
        end else begin
            ctl_reg       <= ctl_next;
            pclath_reg    <= pclath_next;
            pc_high_reg   <= pc_high_next;
            conv_flag_reg <= conv_flag_next;
            rdata_reg     <= rdata_next;
        end
    end

    assign irq_src = {ctl_reg[ICR_B_CONV_EN] & conv_flag_reg,
                      ctl_reg[ICR_B_T0_EN]   & ctl_reg[ICR_B_T0_FLAG],
                      ctl_reg[ICR_B_EXT_EN]  & ctl_reg[ICR_B_EXT_FLAG],
                      ctl_reg[ICR_B_PORT_EN] & ctl_reg[ICR_B_PORT_FLAG]};
    assign irq_req = ctl_reg[ICR_B_GLB_EN] & (|irq_src);             // [R12]
    assign rdata   = rdata_reg;
    assign pc_high = pc_high_reg;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence s_ctl_read;
        rd && hit_ctl;
    endsequence

    sequence s_latch_write;
        wr && hit_pch && !other_rst;
    endsequence

    sequence s_latch_to_pc;
        s_latch_write ##1 (pc_load && !other_rst && !wr);
    endsequence

    sequence s_quiet_write;
        wr && hit_ctl && !timer0_ovf && !evt.ext_edge && !evt.port_change && !other_rst;
    endsequence

    a_ctl_read_back: assert property (s_ctl_read |=> rdata == $past(ctl_reg)) // [R1]
        else $error("interrupt control read data wrong");

    a_mirror_same_reg: assert property ( // [R2]
        (rd && addr == (ICR_ADDR_CTL | ICR_BANK_BIT)) |=> rdata == $past(ctl_reg))
        else $error("mirror address does not reach interrupt control");

    a_flag_set_always: assert property ((timer0_ovf && !other_rst) |=> ctl_reg[ICR_B_T0_FLAG]) // [R3]
        else $error("timer flag not set by its event");

    a_bank_ignored: assert property ( // [R4]
        (wr && addr == (ICR_ADDR_PCH | ICR_BANK_BIT) && !other_rst) |=> pclath_reg == $past(wdata[ICR_PCH_W-1:0]))
        else $error("latch not written from upper bank");

    a_latch_to_pc: assert property (s_latch_to_pc |=> pc_high == $past(wdata[ICR_PCH_W-1:0], 2)) // [R5]
        else $error("program counter high not loaded from latch");

    a_other_rst_vals: assert property ( // [R6]
        (other_rst && !evt.port_change) |=>
            (ctl_reg[ICR_DW-1:1] == ICR_ZERO[ICR_DW-1:1]) && (ctl_reg[0] == $past(ctl_reg[0])))
        else $error("other reset values wrong");

    a_unmapped_zero: assert property ((rd && !hit_ctl && !hit_pch && !hit_pir) |=> rdata == ICR_ZERO) // [R7]
        else $error("unimplemented location does not read zero");

    a_rdata_one_cycle: assert property (!rd |=> rdata == ICR_ZERO) // [R7]
        else $error("read data held beyond its cycle");

    a_conv_flag_set: assert property ((conv_done && !other_rst) |=> conv_flag_reg) // [R10]
        else $error("converter flag not set on completion");

    a_layout_write: assert property (s_quiet_write |=> ctl_reg == $past(wdata)) // [R11]
        else $error("interrupt control write not stored");

    a_flag_sticky: assert property ( // [R12]
        (ctl_reg[ICR_B_EXT_FLAG] && !(wr && hit_ctl) && !other_rst) |=> ctl_reg[ICR_B_EXT_FLAG])
        else $error("flag dropped without software clear");

    a_irq_gated: assert property ( // [R12]
        (ctl_reg[ICR_B_GLB_EN] && ctl_reg[ICR_B_T0_EN] && ctl_reg[ICR_B_T0_FLAG]) |-> irq_req)
        else $error("interrupt request missing");

    a_irq_masked: assert property (!ctl_reg[ICR_B_GLB_EN] |-> !irq_req) // [R12]
        else $error("interrupt requested with global enable clear");
endmodule : icr_top

// ==== verif/interrupt_control_register_test.sv ====
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module interrupt_control_register_test;
    import icr_pkg::*;
    logic                  sys_clk = 1'b0;
    logic                  rst = 1'b1;
    logic [ICR_AW-1:0]     addr = 8'h00;
    logic [ICR_DW-1:0]     wdata = 8'h00;
    logic                  wr = 1'b0;
    logic                  rd = 1'b0;
    logic [ICR_DW-1:0]     rdata;
    logic                  timer0_ovf = 1'b0;
    logic                  conv_done = 1'b0;
    logic                  ext_irq_pin = 1'b0;
    logic [ICR_PORT_W-1:0] port_pins = 4'h0;
    logic                  external_reset_pin_n = 1'b1;
    logic                  wdt_reset = 1'b0;
    logic                  pc_load = 1'b0;
    logic [ICR_PCH_W-1:0]  pc_high;
    logic                  irq_req;
    logic [7:0]            icr = 8'h00;
    logic [7:0]            pch = 8'h00;
    logic [7:0]            d;
    logic                  conv = 1'b0;
    int                    failures = 0;
    int                    check_count = 0;
    int                    seed = 35;

    icr_top icr_top_inst (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .timer0_ovf(timer0_ovf), .conv_done(conv_done), .ext_irq_pin(ext_irq_pin),
        .port_pins(port_pins), .external_reset_pin_n(external_reset_pin_n), .wdt_reset(wdt_reset),
        .pc_load(pc_load), .pc_high(pc_high), .irq_req(irq_req));

    always #25 sys_clk = ~sys_clk;

    function automatic logic mirq();
        return icr[7] & ((icr[6] & conv) | (icr[5] & icr[2]) | (icr[4] & icr[1]) | (icr[3] & icr[0]));
    endfunction : mirq

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : cyc

    task automatic wreg(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge sys_clk);
        wr    <= 1'b0;
    endtask : wreg

    // read data stand only in the cycle after the strobe, so sample just after that edge
    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd   <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask : rchk

    task automatic state_chk();
        rchk(ICR_ADDR_CTL, icr);
        `CHK(irq_req, mirq())
        `CHK(pc_high, pch[4:0])
    endtask : state_chk

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    initial begin
        cyc(5000);
        failures++;
        tally_and_finish();
    end

    initial begin
        cyc(10);
        rst <= 1'b0;
        // stimulus never touches the status register, so its reserved bank bits stay clear
        state_chk();
        rchk(8'h8B, 8'h00);
        rchk(8'h8A, 8'h00);
        rchk(ICR_ADDR_PIR, 8'h00);
        rchk(8'h07, 8'h00);
        $display("test reset_values done");
        for (int i = 0; i < 6; i++) begin
            d = 8'($random(seed));
            wreg((i % 2) ? 8'h8B : 8'h0B, d);
            icr = d;
            rchk((i % 2) ? 8'h0B : 8'h8B, icr);
            `CHK(irq_req, mirq())
        end
        wreg(8'h0B, 8'h00);
        icr = 8'h00;
        $display("test mirror_rw done");
        // the timer, external-pin and port sources set their flags with all enables off
        @(posedge sys_clk) timer0_ovf <= 1'b1;
        @(posedge sys_clk) timer0_ovf <= 1'b0;
        ext_irq_pin <= 1'b1;
        port_pins   <= 4'h5;
        cyc(6);
        icr = 8'h07;
        state_chk();
        cyc(4);
        state_chk();
        for (int b = 0; b < 3; b++) begin
            icr = 8'h80 | (8'h20 >> b) | (8'h04 >> b);
            wreg(8'h0B, icr);
            state_chk();
            icr = icr & 8'hF8;
            wreg(8'h0B, icr);
            state_chk();
        end
        $display("test flags_sticky done");
        @(posedge sys_clk) conv_done <= 1'b1;
        @(posedge sys_clk) conv_done <= 1'b0;
        conv = 1'b1;
        rchk(ICR_ADDR_PIR, 8'h40);
        rchk(8'h8C, 8'h00);
        icr = 8'hC0;
        wreg(8'h0B, icr);
        state_chk();
        wreg(ICR_ADDR_PIR, 8'h00);
        conv = 1'b0;
        state_chk();
        $display("test converter done");
        d = 8'($random(seed));
        wreg(8'h8A, d);
        `CHK(pc_high, 5'h00)
        // load right behind the latch write, the tightest spacing the core can produce
        pc_load <= 1'b1;
        @(posedge sys_clk) pc_load <= 1'b0;
        pch = d & 8'h1F;
        rchk(ICR_ADDR_PCH, d & 8'h1F);
        state_chk();
        // service routine: save latch, use another page, restore before returning
        rchk(ICR_ADDR_PCH, pch);
        wreg(8'h0A, 8'h00);
        wreg(8'h0A, pch);
        @(posedge sys_clk) pc_load <= 1'b1;
        @(posedge sys_clk) pc_load <= 1'b0;
        state_chk();
        $display("test pc_latch done");
        icr = 8'hFF;
        wreg(8'h0B, icr);
        @(posedge sys_clk) conv_done <= 1'b1;
        @(posedge sys_clk) conv_done <= 1'b0;
        @(posedge sys_clk) wdt_reset <= 1'b1;
        @(posedge sys_clk) wdt_reset <= 1'b0;
        icr = 8'h01;
        pch = 8'h00;
        state_chk();
        rchk(ICR_ADDR_PIR, 8'h00);
        rchk(ICR_ADDR_PCH, 8'h00);
        icr = 8'hFE;
        wreg(8'h0B, icr);
        wreg(8'h0A, 8'h1F);
        external_reset_pin_n <= 1'b0;
        cyc(5);
        external_reset_pin_n <= 1'b1;
        cyc(4);
        icr = 8'h00;
        state_chk();
        rchk(ICR_ADDR_PCH, 8'h00);
        $display("test other_reset done");
        wreg(8'h07, 8'hFF);
        wreg(8'h1D, 8'hFF);
        rchk(8'h07, 8'h00);
        rchk(8'h1D, 8'h00);
        state_chk();
        $display("test unmapped done");
        tally_and_finish();
    end
endmodule : interrupt_control_register_test
